// >>> logic/ascp_consts.vh
// register map, field positions and reset values of the serial port
`ifndef ASCP_CONSTS_VH
`define ASCP_CONSTS_VH

// ----------------
// register byte offsets
// ----------------
`define ASCP_OFS_FMT 5'h00
`define ASCP_OFS_CTL 5'h04
`define ASCP_OFS_STAT 5'h08
`define ASCP_OFS_DATA 5'h0C
`define ASCP_OFS_BAUD 5'h10
`define ASCP_OFS_NINTH 5'h14

// ----------------
// format_control_reg fields
// ----------------
`define ASCP_FMT_LOOP 7
`define ASCP_FMT_EN 6
`define ASCP_FMT_INV 5
`define ASCP_FMT_LEN 4
`define ASCP_FMT_WAKE 3
`define ASCP_FMT_IDLE_COUNT_TYPE 2
`define ASCP_FMT_PEN 1
`define ASCP_FMT_PODD 0

// ----------------
// control register fields
// ----------------
`define ASCP_CTL_TXEN 0
`define ASCP_CTL_RXEN 1
`define ASCP_CTL_STBY 2
`define ASCP_CTL_RXIE 3
`define ASCP_CTL_TXIE 4
`define ASCP_CTL_OVERRUN_IRQ_ENABLE 5
`define ASCP_CTL_DMAR 6

// ----------------
// primary_status_reg fields
// ----------------
`define ASCP_ST_TXE 7
`define ASCP_ST_TXD 6
`define ASCP_ST_RXF 5
`define ASCP_ST_IDL 4
`define ASCP_ST_OVR 3
`define ASCP_ST_FRM 1
`define ASCP_ST_PAR 0

// ----------------
// reset values and frame sizes
// ----------------
`define ASCP_FMT_RST 8'h00
`define ASCP_CTL_RST 8'h00
`define ASCP_BAUD_RST 16'h06C8
`define ASCP_FRM_SHORT 4'hA
`define ASCP_FRM_LONG 4'hB
`define ASCP_BITS_SHORT 4'h8
`define ASCP_BITS_LONG 4'h9

`endif

// >>> logic/ascp_bit_timer.v
// bit period timer: mid-bit and end-of-bit pulses from a divisor
module ascp_bit_timer #(
    parameter W = 16
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // control
    input wire run_i,
    input wire [W-1:0] div_i,
    // pulses
    output reg mid_o,
    output reg end_o
);

    reg [W-1:0] cnt_r; // position inside the bit

    // ----------------
    // counter, held at zero while stopped
    // ----------------
    // restarting from zero lets a start edge align the sample point
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= {W{1'b0}};
            mid_o <= 1'b0;
            end_o <= 1'b0;
        end else if (!run_i) begin
            cnt_r <= {W{1'b0}};
            mid_o <= 1'b0;
            end_o <= 1'b0;
        end else begin
            mid_o <= (cnt_r == (div_i >> 1));
            end_o <= (cnt_r >= div_i - 1'b1);
            if (cnt_r >= div_i - 1'b1) begin
                cnt_r <= {W{1'b0}};
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

endmodule // ascp_bit_timer

// >>> logic/ascp_serial_port.v
// asynchronous serial port with format control, status and avalon-mm slave
//
// Summary of operation
// - loop mode feeds transmitter into receiver
// - port enable gates port; clear sets empty/done
// - inversion flips every transmitted level
// - length bit picks 9 or 8 bits
// - wake bit picks address mark or idle
// - idle count starts after stop or start
// - parity sits in character msb
// - parity type: set odd, clear even
// - one start, one stop, 10/11 bits
// - reset clears whole format register
// - port runs in wait; irq wakes cpu
// - dma served in wait without cpu
// - stop mode halts, registers kept
// - debug break protects flags and arming
// - break clears allowed stay cleared
// - enabled port drives transmit pin
// - enabled port makes receive pin input
// - no dma: status then data read clears full
// - status read arms; data read clears errors
// - dma clear leaves overrun set
// - parity type change mid-character may error
// - framing error set with receive full
// - standby masks rx irq until wake
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`include "ascp_consts.vh"

module ascp_serial_port #(
    parameter AW = 5
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // avalon-mm slave
    input wire [AW-1:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // system state
    input wire dma_cycle_i,
    input wire wait_mode_i,
    input wire stop_mode_i,
    input wire break_state_i,
    input wire break_clear_enable_i,
    // shared port pins
    input wire [1:0] port_direction_i,
    input wire [1:0] port_out_i,
    output reg serial_out_pin_o,
    output reg serial_out_pin_oe_o,
    input wire serial_in_pin_i,
    output reg serial_in_pin_o,
    output reg serial_in_pin_oe_o,
    // requests
    output reg irq_o,
    output reg dma_rx_req_o
);

    // ----------------
    // reset release and helpers
    // ----------------
    localparam RX_IDLE = 2'b00;
    localparam RX_START = 2'b01;
    localparam RX_DATA = 2'b10;
    localparam RX_STOP = 2'b11;

    reg rst_meta_r; // first reset stage
    reg rst_n; // released reset copy

    // reset asserts at once, releases after two edges
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // parity over the bits below the character msb
    function ascp_par;
        input [8:0] c;
        input m;
        input odd;
        begin
            ascp_par = (m ? ^c[7:0] : ^c[6:0]) ^ odd;
        end
    endfunction

    // ----------------
    // registers
    // ----------------
    reg [7:0] fmt_r; // format_control_reg
    reg [7:0] ctl_r; // enables, standby, irq enables
    reg [15:0] baud_r; // clocks per bit
    reg t8_r; // ninth transmit bit
    reg r8_r; // ninth receive bit
    reg [7:0] tx_buf_r; // transmit data
    reg [7:0] rx_data_r; // received data
    reg txe_r, txd_r, rxf_r, idl_r, ovr_r, frm_r, par_r; // status flags
    reg arm_r; // status read seen, clear pending
    reg ack_r; // answer phase of bus cycle

    wire en = fmt_r[`ASCP_FMT_EN];
    wire m9 = fmt_r[`ASCP_FMT_LEN];
    wire parity_enable = fmt_r[`ASCP_FMT_PEN];
    wire podd = fmt_r[`ASCP_FMT_PODD];
    wire stby = ctl_r[`ASCP_CTL_STBY];
    wire rxon = en & ctl_r[`ASCP_CTL_RXEN] & ~stop_mode_i;
    wire dma_srv = ctl_r[`ASCP_CTL_RXIE] & ctl_r[`ASCP_CTL_DMAR];
    // cpu is locked out in wait, dma still gets through
    wire acc_ok = ~wait_mode_i | dma_cycle_i;
    wire req = (avs_read_i | avs_write_i) & ack_r & acc_ok;
    wire wr = req & avs_write_i;
    wire rd = req & avs_read_i;
    wire protect = break_state_i & ~break_clear_enable_i;
    wire rd_stat = rd & (avs_address_i == `ASCP_OFS_STAT) & ~protect;
    wire rd_data = rd & (avs_address_i == `ASCP_OFS_DATA) & ~protect;
    wire wr_data = wr & (avs_address_i == `ASCP_OFS_DATA);

    // ----------------
    // avalon handshake and read data
    // ----------------
    reg [31:0] rdata; // read mux

    always @* begin
        rdata = 32'h0;
        case (avs_address_i)
            `ASCP_OFS_FMT: rdata[7:0] = fmt_r;
            `ASCP_OFS_CTL: rdata[7:0] = ctl_r;
            `ASCP_OFS_STAT: begin
                rdata[`ASCP_ST_TXE] = txe_r;
                rdata[`ASCP_ST_TXD] = txd_r;
                rdata[`ASCP_ST_RXF] = rxf_r;
                rdata[`ASCP_ST_IDL] = idl_r;
                rdata[`ASCP_ST_OVR] = ovr_r;
                rdata[`ASCP_ST_FRM] = frm_r;
                rdata[`ASCP_ST_PAR] = par_r;
            end
            `ASCP_OFS_DATA: rdata[7:0] = rx_data_r;
            `ASCP_OFS_BAUD: rdata[15:0] = baud_r;
            `ASCP_OFS_NINTH: rdata[1:0] = {t8_r, r8_r};
            default: rdata = 32'h0; // unmapped reads zero
        endcase
        if (!acc_ok) begin
            rdata = 32'h0;
        end
    end

    // first edge captures data and drops waitrequest, second completes
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0;
        end else if (ack_r) begin
            ack_r <= 1'b0;
            avs_waitrequest_o <= 1'b1;
        end else if (avs_read_i | avs_write_i) begin
            ack_r <= 1'b1;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= rdata;
        end
    end

    // ----------------
    // receive line: pin sync and loop select
    // ----------------
    reg rx_meta_r, rx_sync_r; // two-stage synchroniser
    reg tx_line_r; // transmitter output before inversion
    reg rx_prev_r; // previous line level

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
        end else begin
            rx_meta_r <= serial_in_pin_i;
            rx_sync_r <= rx_meta_r;
        end
    end

    // loop takes the uninverted transmitter so frames stay decodable
    wire rx_line = fmt_r[`ASCP_FMT_LOOP] ? tx_line_r : rx_sync_r;

    // ----------------
    // transmitter
    // ----------------
    reg [10:0] tx_sh_r; // frame shifter, lsb first
    reg [3:0] tx_cnt_r; // bits left
    reg tx_busy_r;
    wire tx_end;
    wire [8:0] tx_ch = {t8_r, tx_buf_r};
    wire tx_p = ascp_par(tx_ch, m9, podd);
    wire tx_load = ~tx_busy_r & ~txe_r & ctl_r[`ASCP_CTL_TXEN] & en & ~stop_mode_i;

    ascp_bit_timer #(.W(16)) u_tx_tmr (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .run_i(tx_busy_r & en & ~stop_mode_i),
        .div_i(baud_r),
        .mid_o(),
        .end_o(tx_end)
    );

    // frame build: start 0, bits, optional parity at msb, stop 1
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_sh_r <= 11'h7FF;
            tx_cnt_r <= 4'h0;
            tx_busy_r <= 1'b0;
            tx_line_r <= 1'b1;
        end else if (!en) begin
            tx_busy_r <= 1'b0;
            tx_line_r <= 1'b1;
        end else if (tx_load) begin
            tx_busy_r <= 1'b1;
            tx_line_r <= 1'b0;
            if (m9) begin
                tx_sh_r <= {1'b1, (parity_enable ? tx_p : tx_ch[8]), tx_ch[7:0], 1'b0};
                tx_cnt_r <= `ASCP_FRM_LONG;
            end else begin
                tx_sh_r <= {2'b11, (parity_enable ? tx_p : tx_ch[7]), tx_ch[6:0], 1'b0};
                tx_cnt_r <= `ASCP_FRM_SHORT;
            end
        end else if (tx_busy_r & tx_end) begin
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
            tx_line_r <= tx_sh_r[1];
            tx_cnt_r <= tx_cnt_r - 4'h1;
            if (tx_cnt_r == 4'h1) begin
                tx_busy_r <= 1'b0;
                tx_line_r <= 1'b1;
            end
        end
    end

    wire tx_fin = tx_busy_r & tx_end & (tx_cnt_r == 4'h1) & en;

    // ----------------
    // receiver
    // ----------------
    reg [1:0] rx_st_r;
    reg [8:0] rx_sh_r; // shifted in from the top
    reg [3:0] rx_cnt_r;
    reg [3:0] idle_cnt_r; // consecutive ones
    reg idle_seen_r; // idle reported until next zero
    wire rx_mid, idle_tick;
    wire [8:0] rx_ch = m9 ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
    wire rx_msb = m9 ? rx_ch[8] : rx_ch[7];
    wire rx_done = (rx_st_r == RX_STOP) & rx_mid & rxon;
    // standby drops characters unless the wake bit selects address mark and an address mark arrives
    wire rx_take = ~stby | (fmt_r[`ASCP_FMT_WAKE] & rx_msb);
    wire [3:0] frm_len = m9 ? `ASCP_FRM_LONG : `ASCP_FRM_SHORT;
    wire idle_ev = (idle_cnt_r >= frm_len) & ~idle_seen_r & rxon;

    ascp_bit_timer #(.W(16)) u_rx_tmr (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .run_i((rx_st_r != RX_IDLE) & rxon),
        .div_i(baud_r),
        .mid_o(rx_mid),
        .end_o()
    );

    // free bit clock for counting idle line time
    ascp_bit_timer #(.W(16)) u_idle_tmr (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .run_i((rx_st_r == RX_IDLE) & rxon),
        .div_i(baud_r),
        .mid_o(idle_tick),
        .end_o()
    );

    // frame receive state machine
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_r <= RX_IDLE;
            rx_sh_r <= 9'h000;
            rx_cnt_r <= 4'h0;
            rx_prev_r <= 1'b1;
        end else if (!rxon) begin
            rx_prev_r <= 1'b1; // halted; receive state is kept unless the port is disabled
            if (!en) begin
                rx_st_r <= RX_IDLE;
            end
        end else begin
            rx_prev_r <= rx_line;
            case (rx_st_r)
                RX_IDLE: begin
                    if (rx_prev_r & ~rx_line) begin
                        rx_st_r <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_mid) begin
                        rx_st_r <= rx_line ? RX_IDLE : RX_DATA;
                        rx_cnt_r <= m9 ? `ASCP_BITS_LONG : `ASCP_BITS_SHORT;
                    end
                end
                RX_DATA: begin
                    if (rx_mid) begin
                        rx_sh_r <= {rx_line, rx_sh_r[8:1]};
                        rx_cnt_r <= rx_cnt_r - 4'h1;
                        if (rx_cnt_r == 4'h1) begin
                            rx_st_r <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_mid) begin
                        rx_st_r <= RX_IDLE;
                    end
                end
                default: rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // idle counting: from the start bit, or only after the stop bit
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt_r <= 4'h0;
            idle_seen_r <= 1'b0;
        end else if (!rxon || !rx_line) begin
            idle_cnt_r <= 4'h0;
            idle_seen_r <= 1'b0;
        end else if (rx_done & fmt_r[`ASCP_FMT_IDLE_COUNT_TYPE]) begin
            idle_cnt_r <= 4'h0;
        end else begin
            if (idle_ev) begin
                idle_seen_r <= 1'b1;
            end
            if (idle_cnt_r < frm_len) begin
                if (((rx_st_r == RX_IDLE) & idle_tick)
                    | (rx_st_r[1] & rx_mid & ~fmt_r[`ASCP_FMT_IDLE_COUNT_TYPE])) begin
                    idle_cnt_r <= idle_cnt_r + 4'h1;
                end
            end
        end
    end

    // ----------------
    // software registers
    // ----------------
    // tx/rx enables only accept writes while the port is enabled
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fmt_r <= `ASCP_FMT_RST;
            ctl_r <= `ASCP_CTL_RST;
            baud_r <= `ASCP_BAUD_RST;
            t8_r <= 1'b0;
            tx_buf_r <= 8'h00;
        end else begin
            if (wr & (avs_address_i == `ASCP_OFS_FMT)) begin
                fmt_r <= avs_writedata_i[7:0];
            end
            if (wr & (avs_address_i == `ASCP_OFS_CTL)) begin
                ctl_r <= avs_writedata_i[7:0];
                if (!en) begin
                    ctl_r[`ASCP_CTL_TXEN] <= ctl_r[`ASCP_CTL_TXEN];
                    ctl_r[`ASCP_CTL_RXEN] <= ctl_r[`ASCP_CTL_RXEN];
                end
            end else if (rx_done & stby & rx_take) begin
                ctl_r[`ASCP_CTL_STBY] <= 1'b0;
            end else if (idle_ev & stby & ~fmt_r[`ASCP_FMT_WAKE]) begin
                ctl_r[`ASCP_CTL_STBY] <= 1'b0;
            end
            if (wr & (avs_address_i == `ASCP_OFS_BAUD)) begin
                baud_r <= avs_writedata_i[15:0];
            end
            if (wr & (avs_address_i == `ASCP_OFS_NINTH)) begin
                t8_r <= avs_writedata_i[1];
            end
            if (wr_data) begin
                tx_buf_r <= avs_writedata_i[7:0];
            end
        end
    end

    // ----------------
    // status flags: set wins over clear
    // ----------------
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            txe_r <= 1'b1;
            txd_r <= 1'b1;
            rxf_r <= 1'b0;
            idl_r <= 1'b0;
            ovr_r <= 1'b0;
            frm_r <= 1'b0;
            par_r <= 1'b0;
            arm_r <= 1'b0;
            rx_data_r <= 8'h00;
            r8_r <= 1'b0;
        end else begin
            // arming and clearing stand still while protected
            if (rd_stat) begin
                arm_r <= 1'b1;
            end else if (rd_data) begin
                arm_r <= 1'b0;
            end
            if (rd_data & (arm_r | dma_srv)) begin
                rxf_r <= 1'b0;
            end
            if (rd_data & arm_r) begin
                idl_r <= 1'b0;
                ovr_r <= 1'b0;
                frm_r <= 1'b0;
                par_r <= 1'b0;
            end
            if (wr_data & ~protect) begin
                txe_r <= 1'b0;
                txd_r <= 1'b0;
            end
            if (tx_load) begin
                txe_r <= 1'b1;
            end
            if (tx_fin & txe_r) begin
                txd_r <= 1'b1;
            end
            if (!en) begin
                txe_r <= 1'b1;
                txd_r <= 1'b1;
            end
            if (idle_ev & ~(stby & ~fmt_r[`ASCP_FMT_WAKE])) begin
                idl_r <= 1'b1;
            end
            if (rx_done & rx_take) begin
                if (rxf_r & ~(rd_data & (arm_r | dma_srv))) begin
                    ovr_r <= 1'b1; // old data kept, new lost
                end else begin
                    rx_data_r <= rx_ch[7:0];
                    r8_r <= m9 ? rx_ch[8] : rx_ch[7];
                    rxf_r <= 1'b1;
                    frm_r <= ~rx_line;
                    // parity type read live, so a mid-frame change can error
                    par_r <= parity_enable & (ascp_par(rx_ch, m9, podd) != rx_msb);
                end
            end
        end
    end

    // ----------------
    // pins and requests
    // ----------------
    // enabled port owns both pins regardless of direction bits
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            serial_out_pin_o <= 1'b0;
            serial_out_pin_oe_o <= 1'b0;
            serial_in_pin_o <= 1'b0;
            serial_in_pin_oe_o <= 1'b0;
            irq_o <= 1'b0;
            dma_rx_req_o <= 1'b0;
        end else begin
            serial_out_pin_o <= en ? (tx_line_r ^ fmt_r[`ASCP_FMT_INV]) : port_out_i[0];
            serial_out_pin_oe_o <= en | port_direction_i[0];
            serial_in_pin_o <= port_out_i[1];
            serial_in_pin_oe_o <= ~en & port_direction_i[1];
            // irq keeps running in wait so it can end wait
            irq_o <= en & ((txe_r & ctl_r[`ASCP_CTL_TXIE])
                | (rxf_r & ctl_r[`ASCP_CTL_RXIE] & ~ctl_r[`ASCP_CTL_DMAR] & ~stby)
                | (ovr_r & ctl_r[`ASCP_CTL_OVERRUN_IRQ_ENABLE]));
            dma_rx_req_o <= en & rxf_r & dma_srv;
        end
    end

endmodule // ascp_serial_port

// >>> tb/ascp_serial_port_props.sv
// checker of bus handshake, wait mode answers, pin ownership and stop hold
module ascp_serial_port_props #(
    parameter AW = 5
) (
    // clock and reset
    input logic clk_i,
    input logic rst_n_i,
    // bus
    input logic avs_read_i,
    input logic avs_write_i,
    input logic [31:0] avs_readdata_o,
    input logic avs_waitrequest_o,
    // system state and pins
    input logic dma_cycle_i,
    input logic wait_mode_i,
    input logic stop_mode_i,
    input logic [1:0] port_direction_i,
    input logic [1:0] port_out_i,
    input logic serial_out_pin_o,
    input logic serial_out_pin_oe_o,
    input logic serial_in_pin_oe_o
);
    // armed past the design's own reset copy
    logic [2:0] up_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) up_r <= 3'h0;
        else if (!up_r[2]) up_r <= up_r + 3'h1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!up_r[2]);
    // request still held off
    sequence req_s;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    // cpu read in wait
    sequence cpu_rd_s;
        avs_read_i && avs_waitrequest_o && wait_mode_i && !dma_cycle_i;
    endsequence
    // three frozen cycles
    sequence stop_s;
        stop_mode_i [*3];
    endsequence
    wait_ans_a: assert property (req_s |=> !avs_waitrequest_o)
        else $error("request not answered next cycle");
    wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer longer than one cycle");
    wait_idle_a: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
        else $error("answer without request");
    rd_hold_a: assert property (!(avs_read_i || avs_write_i) |=> $stable(avs_readdata_o))
        else $error("read data moved without request");
    cpu_zero_a: assert property (cpu_rd_s |=> avs_readdata_o == 32'h0)
        else $error("cpu read in wait returned data");
    out_drive_a: assert property (!serial_out_pin_oe_o |-> !$past(port_direction_i[0]))
        else $error("out pin undriven");
    in_input_a: assert property (serial_in_pin_oe_o |-> $past(port_direction_i[1]))
        else $error("in pin driven unasked");
    stop_hold_a: assert property (stop_s ##0 $stable(port_out_i) |-> $stable(serial_out_pin_o))
        else $error("line moved in stop");
endmodule // ascp_serial_port_props

bind ascp_serial_port ascp_serial_port_props #(.AW(AW)) u_props (.*);

// >>> tb/ascp_link_partner.sv
// far side of the serial line: sends frames and captures frames
module ascp_link_partner #(
    parameter int BT = 8
) (
    // clock
    input wire logic clk_i,
    // line from the port, inverted back on request
    input wire logic line_i,
    input wire logic inv_i,
    input wire logic [3:0] n_i,
    // line into the port and captured frame
    output logic line_o,
    output logic got_o,
    output logic [10:0] bits_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idles high like any asynchronous line
    initial line_o = 1'b1;
    // whole frame lsb first, one bit per BT clocks
    task automatic send(input logic [10:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            line_o <= f[i];
            repeat (BT) @(posedge clk_i);
        end
        line_o <= 1'b1;
    endtask
    // capture only while a length is set, so config glitches are ignored
    initial begin
        got_o = 1'b0;
        bits_o = '0;
        forever begin
            @(posedge clk_i iff (n_i != 0 && (line_i ^ inv_i) === 1'b0));
            repeat (BT / 2) @(posedge clk_i);
            for (int i = 0; i < n_i; i++) begin
                bits_o[i] = line_i ^ inv_i;
                repeat (BT) @(posedge clk_i);
            end
            got_o = 1'b1;
            repeat (BT) @(posedge clk_i);
            got_o = 1'b0;
        end
    end
endmodule // ascp_link_partner

// >>> tb/tb_top.sv
// self-checking bench of the serial port
`include "ascp_consts.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // signals
    // ----
    logic clk_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0, dma_cycle_i = 0;
    logic wait_mode_i = 0, stop_mode_i = 0, inv = 0, got, irq_o;
    logic [4:0] avs_address_i = 0;
    logic [31:0] avs_writedata_i = 0, avs_readdata_o;
    logic avs_waitrequest_o, serial_out_pin_o, serial_out_pin_oe_o, serial_in_pin_i;
    logic [3:0] n_bits = 0;
    logic [10:0] bits;
    logic [7:0] d;
    logic [8:0] c;
    logic [7:0] cfg[6] = '{8'h00, 8'h10, 8'h02, 8'h03, 8'h12, 8'h13};
    logic [63:0] rq[$]; // mask and value of each pending read
    logic [10:0] fq[$]; // frames due at the far side
    int error_cnt = 0, samples_checked = 0, seed = 32'h794f, cyc = 0, t, m;
    ascp_serial_port dut (.*, .break_state_i(1'b0), .break_clear_enable_i(1'b0),
        .port_direction_i(2'b11), .port_out_i(2'b00), .serial_in_pin_o(),
        .serial_in_pin_oe_o(), .dma_rx_req_o());
    ascp_link_partner #(.BT(8)) u_p (.clk_i, .line_i(serial_out_pin_o), .inv_i(inv),
        .n_i(n_bits), .line_o(serial_in_pin_i), .got_o(got), .bits_o(bits));
    initial forever #2.5 clk_i = ~clk_i;
    // ----
    // helpers
    // ----
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s exp %h seen %h", nm, e, s);
        end
    endtask
    // hold request until waitrequest low at a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v);
        int k = 0;
        avs_address_i <= a;
        avs_writedata_i <= v;
        avs_write_i <= w;
        avs_read_i <= !w;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0 && ++k < 50);
        if (k == 50) error_cnt++;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] mk, input logic [31:0] e);
        rq.push_back({mk, e});
        bus(1'b0, a, 32'h0);
    endtask
    task automatic till(ref logic s);
        for (t = 0; t < 300 && s !== 1'b1; t++) @(posedge clk_i);
        if (t == 300) error_cnt++;
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    function automatic logic [10:0] fr(input logic [8:0] x, input int n);
        return 11'((({2'h0, x} & ((11'h1 << n) - 11'h1)) << 1) | (11'h1 << (n + 1)));
    endfunction
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watchers take the oldest note whenever a result shows
    always @(posedge clk_i) if (avs_read_i && avs_waitrequest_o === 1'b0) begin
        chk("readdata", avs_readdata_o & rq[0][63:32], rq[0][31:0]);
        void'(rq.pop_front());
    end
    always @(posedge got) begin
        chk("frame", 32'(bits) & ((32'h1 << n_bits) - 32'h1), 32'(fq[0]));
        void'(fq.pop_front());
    end
    always @(posedge clk_i) if (++cyc == 20000) begin
        error_cnt++;
        end_of_test;
    end
    // ----
    // scenarios
    // ----
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(`ASCP_OFS_FMT, 32'hFF, 32'h0);
        rd(5'h18, 32'hFFFFFFFF, 32'h0);
        repeat (4) begin
            d = 8'($random(seed)) & 8'h3F;
            wr(`ASCP_OFS_FMT, d);
            rd(`ASCP_OFS_FMT, 32'hFF, d);
        end
        note("format");
        wr(`ASCP_OFS_BAUD, 32'h8);
        for (int k = 0; k < 6; k++) begin
            n_bits <= 4'h0;
            wr(`ASCP_OFS_FMT, 8'h40 | cfg[k] | (k % 2) * 32);
            wr(`ASCP_OFS_CTL, 32'h3);
            d = 8'($random(seed));
            wr(`ASCP_OFS_NINTH, {d[0], 1'b0});
            inv <= k[0];
            n_bits <= cfg[k][4] ? `ASCP_FRM_LONG : `ASCP_FRM_SHORT;
            m = cfg[k][4] ? 9 : 8;
            c = cfg[k][4] ? {d[0], d} : {1'b0, d};
            if (cfg[k][1]) c[m-1] = ^(c & ((9'h1 << (m - 1)) - 9'h1)) ^ cfg[k][0];
            fq.push_back(fr(c, m));
            wr(`ASCP_OFS_DATA, d);
            till(got);
        end
        note("transmit");
        n_bits <= 4'h0;
        inv <= 1'b0;
        wr(`ASCP_OFS_FMT, 32'h40);
        wr(`ASCP_OFS_CTL, 32'hB);
        for (int k = 0; k < 3; k++) begin
            d = 8'($random(seed));
            if (k == 2) wr(`ASCP_OFS_FMT, 32'h42);
            u_p.send(fr(k == 2 ? {2'h0, ~^d[6:0], d[6:0]} : d, 8) & ~(11'(k == 1) << 9), 10);
            till(irq_o);
            rd(`ASCP_OFS_STAT, 32'h23, k == 0 ? 32'h20 : k == 1 ? 32'h22 : 32'h21);
            rd(`ASCP_OFS_DATA, 32'h7F, d & 8'h7F);
            rd(`ASCP_OFS_STAT, 32'h23, 32'h0);
        end
        note("receive");
        wr(`ASCP_OFS_FMT, 32'hC0);
        fork
            u_p.send(11'h0, 11);
            wr(`ASCP_OFS_DATA, 32'h3C);
        join
        till(irq_o);
        rd(`ASCP_OFS_STAT, 32'h20, 32'h20);
        rd(`ASCP_OFS_DATA, 32'hFF, 32'h3C);
        stop_mode_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        stop_mode_i <= 1'b0;
        rd(`ASCP_OFS_FMT, 32'hFF, 32'hC0);
        wait_mode_i <= 1'b1;
        rd(`ASCP_OFS_FMT, 32'hFF, 32'h0);
        dma_cycle_i <= 1'b1;
        rd(`ASCP_OFS_FMT, 32'hFF, 32'hC0);
        wait_mode_i <= 1'b0;
        dma_cycle_i <= 1'b0;
        note("loop and low power");
        wr(`ASCP_OFS_FMT, 32'h40);
        wr(`ASCP_OFS_DATA, 32'h55);
        wr(`ASCP_OFS_FMT, 32'h0);
        rd(`ASCP_OFS_STAT, 32'hC0, 32'hC0);
        note("disable");
        end_of_test;
    end
endmodule // tb_top
